// ---- include/frac_brg_params.svh ----
// offsets-free constants of the fractional baud rate generator: resets, fields, timing
`ifndef FRAC_BRG_PARAMS_SVH
`define FRAC_BRG_PARAMS_SVH

// reset values of the divisor registers
`define DIV_LOW_RESET 8'h01
`define DIV_HIGH_RESET 8'h00
`define DIV_FRAC_RESET 8'h00

// modem control register: prescaler select bit
`define MCR_PRESCALE_BIT 7

// fraction and sampling register fields
`define FRAC_FIELD_MSB 3
`define FRAC_FIELD_LSB 0
`define MODE_FIELD_MSB 5
`define MODE_FIELD_LSB 4

// sampling-mode encodings
`define MODE_16X 2'b00
`define MODE_8X 2'b01
`define MODE_4X 2'b10

// sampling clocks per bit, as last-count values
`define SAMPLES_16X_LAST 4'hf
`define SAMPLES_8X_LAST 4'h7
`define SAMPLES_4X_LAST 4'h3

// prescaler divide-by-4 last count
`define PRESCALE_BY4_LAST 2'h3

// reference clock rate in hertz
`define REF_CLOCK_HZ 25000000

`endif

// ---- include/frac_brg_pkg.sv ----
// types shared by the fractional baud rate generator files
package frac_brg_pkg;

	// which register of the selected channel a host access reaches
	typedef enum logic [1:0] {
		REG_DIV_LOW,
		REG_DIV_HIGH,
		REG_DIV_FRAC,
		REG_MODEM_CTRL
	} reg_sel_t;

	// decoded sampling rate
	typedef enum logic [1:0] {
		SAMPLE_16X,
		SAMPLE_8X,
		SAMPLE_4X
	} sample_rate_t;

endpackage

// ---- hw/rate_divider.sv ----
// prescaler and fractional divider of one channel
`timescale 1ns/1ps
`include "frac_brg_params.svh"

module rate_divider import frac_brg_pkg::*; #(
	parameter int INT_W = 16,
	parameter int FRAC_W = 4
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic prescale_by4_in,
	input wire logic [INT_W-1:0] int_div_in,
	input wire logic [FRAC_W-1:0] frac_div_in,
	input wire logic restart_in,
	output logic tick_out
);

	logic [1:0] pre_cnt_reg;
	logic pre_en;
	logic [INT_W:0] cnt_reg;
	logic [FRAC_W-1:0] acc_reg;
	logic [FRAC_W:0] acc_sum;
	logic [INT_W:0] last_count;
	logic [INT_W-1:0] int_eff;

	////////////////////////////////////////////////////////////////
	// prescaler: every reference cycle, or every fourth one
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_cnt_reg <= 2'h0;
		end else if (restart_in || !prescale_by4_in) begin
			pre_cnt_reg <= 2'h0;
		end else begin
			pre_cnt_reg <= pre_cnt_reg + 2'h1;
		end
	end

	assign pre_en = !prescale_by4_in || (pre_cnt_reg == `PRESCALE_BY4_LAST);

	////////////////////////////////////////////////////////////////
	// period length: integer part, stretched by one on fraction carry
	assign int_eff = (int_div_in == '0) ? INT_W'(1) : int_div_in;
	assign acc_sum = {1'b0, acc_reg} + {1'b0, frac_div_in};
	assign last_count = {1'b0, int_eff} - (INT_W+1)'(1) + (INT_W+1)'(acc_sum[FRAC_W]);

	// divider counter and fraction accumulator advance on prescaled enables
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_reg <= '0;
			acc_reg <= '0;
			tick_out <= 1'b0;
		end else if (restart_in) begin
			cnt_reg <= '0;
			acc_reg <= '0;
			tick_out <= 1'b0;
		end else if (pre_en && (cnt_reg >= last_count)) begin
			cnt_reg <= '0;
			acc_reg <= acc_sum[FRAC_W-1:0];
			tick_out <= 1'b1;
		end else begin
			if (pre_en) begin
				cnt_reg <= cnt_reg + (INT_W+1)'(1);
			end
			tick_out <= 1'b0;
		end
	end

endmodule

// ---- hw/frac_baud_gen.sv ----
// multi-channel fractional baud rate generator with its divisor registers
`timescale 1ns/1ps
`include "frac_brg_params.svh"

module frac_baud_gen import frac_brg_pkg::*; #(
	parameter int NUM_CHANNELS = 2,
	parameter int CH_W = 1
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic [CH_W-1:0] chan_sel_in,
	input wire reg_sel_t reg_sel_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out,
	output logic [NUM_CHANNELS-1:0] sample_tick_out,
	output logic [NUM_CHANNELS-1:0] bit_tick_out,
	output sample_rate_t sample_rate_out [NUM_CHANNELS]
);

	// divisor and prescaler state of every channel
	logic [7:0] div_low_reg [NUM_CHANNELS];
	logic [7:0] div_high_reg [NUM_CHANNELS];
	logic [7:0] div_frac_reg [NUM_CHANNELS];
	logic prescale_reg [NUM_CHANNELS];
	logic [3:0] sample_cnt_reg [NUM_CHANNELS];
	logic [NUM_CHANNELS-1:0] restart;
	logic [NUM_CHANNELS-1:0] tick;
	logic [7:0] rd_data_next;

	////////////////////////////////////////////////////////////////
	// per-channel generator, registers and bit timing
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
			logic wr_hit;
			logic [3:0] samples_last;
			sample_rate_t rate;

			// a write reaches this channel only when it is selected
			assign wr_hit = wr_en_in && (chan_sel_in == CH_W'(ch));

			// divisor registers, host writable
			always_ff @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					div_low_reg[ch] <= `DIV_LOW_RESET;
					div_high_reg[ch] <= `DIV_HIGH_RESET;
					div_frac_reg[ch] <= `DIV_FRAC_RESET;
				end else if (wr_hit) begin
					if (reg_sel_in == REG_DIV_LOW) begin
						div_low_reg[ch] <= wr_data_in;
					end else if (reg_sel_in == REG_DIV_HIGH) begin
						div_high_reg[ch] <= wr_data_in;
					end else if (reg_sel_in == REG_DIV_FRAC) begin
						div_frac_reg[ch] <= wr_data_in;
					end
				end
			end

			// prescaler select, held from the modem control register
			always_ff @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					prescale_reg[ch] <= 1'b0;
				end else if (wr_hit && (reg_sel_in == REG_MODEM_CTRL)) begin
					prescale_reg[ch] <= wr_data_in[`MCR_PRESCALE_BIT];
				end
			end

			// a divisor or prescaler write restarts the period cleanly
			assign restart[ch] = wr_hit;

			// one divider per channel, shared by its sample tick output and bit timing
			rate_divider #(
				.INT_W(16),
				.FRAC_W(4)
			) u_rate_divider (
				.mclk_in(mclk_in),
				.arst_n_in(arst_n_in),
				.prescale_by4_in(prescale_reg[ch]),
				.int_div_in({div_high_reg[ch], div_low_reg[ch]}),
				.frac_div_in(div_frac_reg[ch][`FRAC_FIELD_MSB:`FRAC_FIELD_LSB]),
				.restart_in(restart[ch]),
				.tick_out(tick[ch])
			);

			// sampling-mode decode; reserved code falls back to 16X
			always_comb begin
				case (div_frac_reg[ch][`MODE_FIELD_MSB:`MODE_FIELD_LSB])
					`MODE_8X: begin
						rate = SAMPLE_8X;
						samples_last = `SAMPLES_8X_LAST;
					end
					`MODE_4X: begin
						rate = SAMPLE_4X;
						samples_last = `SAMPLES_4X_LAST;
					end
					default: begin
						rate = SAMPLE_16X;
						samples_last = `SAMPLES_16X_LAST;
					end
				endcase
			end

			assign sample_rate_out[ch] = rate;
			assign sample_tick_out[ch] = tick[ch];

			// bit timing: 16, 8 or 4 sampling clocks per bit; fractional
			// stretches land unevenly across a bit in 8X and 4X, which is
			// the permitted bit-time jitter
			always_ff @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					sample_cnt_reg[ch] <= 4'h0;
					bit_tick_out[ch] <= 1'b0;
				end else if (restart[ch]) begin
					sample_cnt_reg[ch] <= 4'h0;
					bit_tick_out[ch] <= 1'b0;
				end else if (tick[ch] && (sample_cnt_reg[ch] >= samples_last)) begin
					sample_cnt_reg[ch] <= 4'h0;
					bit_tick_out[ch] <= 1'b1;
				end else begin
					if (tick[ch]) begin
						sample_cnt_reg[ch] <= sample_cnt_reg[ch] + 4'h1;
					end
					bit_tick_out[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// read mux: selected channel and register, other modem bits read zero
	always_comb begin
		rd_data_next = 8'h00;
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			if (chan_sel_in == CH_W'(i)) begin
				if (reg_sel_in == REG_DIV_LOW) begin
					rd_data_next = div_low_reg[i];
				end else if (reg_sel_in == REG_DIV_HIGH) begin
					rd_data_next = div_high_reg[i];
				end else if (reg_sel_in == REG_DIV_FRAC) begin
					rd_data_next = div_frac_reg[i];
				end else begin
					rd_data_next = {prescale_reg[i], 7'h00};
				end
			end
		end
	end

	// read data is registered and held until the next read
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_out <= 8'h00;
		end else if (rd_en_in) begin
			rd_data_out <= rd_data_next;
		end
	end

endmodule

// ---- test/frac_baud_props.sv ----
// port checker for the fractional baud rate generator
`timescale 1ns/1ps
module frac_baud_props import frac_brg_pkg::*; #(
	parameter int NUM_CHANNELS = 2,
	parameter int CH_W = 1
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic [CH_W-1:0] chan_sel_in,
	input wire reg_sel_t reg_sel_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [NUM_CHANNELS-1:0] sample_tick_out,
	input wire logic [NUM_CHANNELS-1:0] bit_tick_out,
	input wire sample_rate_t sample_rate_out [NUM_CHANNELS]
);
	sample_rate_t exp_rate;
	// mode a fraction write should select, reserved code as 16x
	assign exp_rate = (wr_data_in[5:4] == 2'b01) ? SAMPLE_8X :
		(wr_data_in[5:4] == 2'b10) ? SAMPLE_4X : SAMPLE_16X;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	////////////////////////////////////////////////////////////////////////////////
	a_mode_reset: assert property (
		$rose(arst_n_in) |-> sample_rate_out[0] == SAMPLE_16X) else $error("mode after reset");
	a_mode_write: assert property (
		wr_en_in && chan_sel_in == 0 && reg_sel_in == REG_DIV_FRAC
		|=> sample_rate_out[0] == $past(exp_rate)) else $error("mode not taken");
	a_write_restart: assert property (
		wr_en_in && chan_sel_in == 0 |=> !sample_tick_out[0] && !bit_tick_out[0])
		else $error("tick after write");
	a_chan_isolate: assert property (
		wr_en_in && chan_sel_in == 1 |=> !sample_tick_out[1]) else $error("second channel tick");
	a_bit_follows: assert property (
		bit_tick_out[0] |-> $past(sample_tick_out[0])) else $error("bit without sample");
	a_bit_spacing: assert property (
		bit_tick_out[0] |=> !bit_tick_out[0] [*3]) else $error("bit ticks too close");
	a_ctrl_read: assert property (
		rd_en_in && reg_sel_in == REG_MODEM_CTRL |=> rd_data_out[6:0] == 7'h00)
		else $error("control read bits");
	a_read_hold: assert property (
		!rd_en_in |=> $stable(rd_data_out)) else $error("read data moved");
endmodule

bind frac_baud_gen frac_baud_props #(.NUM_CHANNELS(NUM_CHANNELS), .CH_W(CH_W)) i_frac_baud_props (
	.mclk_in, .arst_n_in, .chan_sel_in, .reg_sel_in, .wr_en_in, .rd_en_in, .wr_data_in,
	.rd_data_out, .sample_tick_out, .bit_tick_out, .sample_rate_out);

// ---- test/frac_baud_gen_tb.sv ----
// self-checking bench for the fractional baud rate generator
`timescale 1ns/1ps
module frac_baud_gen_tb import frac_brg_pkg::*;;
	logic mclk_in = 0, arst_n_in = 0, wr_en_in = 0, rd_en_in = 0;
	logic [0:0] chan_sel_in = 0;
	reg_sel_t reg_sel_in = REG_DIV_LOW;
	logic [7:0] wr_data_in = 0, rd_data_out, rd_v;
	logic [1:0] sample_tick_out, bit_tick_out;
	sample_rate_t sample_rate_out [2];
	int errors = 0, checks = 0, ns, nb, n1;
	frac_baud_gen #(.NUM_CHANNELS(2), .CH_W(1)) i_frac_baud_gen (.mclk_in, .arst_n_in,
		.chan_sel_in, .reg_sel_in, .wr_en_in, .rd_en_in, .wr_data_in, .rd_data_out,
		.sample_tick_out, .bit_tick_out, .sample_rate_out);
	// 25 MHz reference clock
	initial begin
		forever #20 mclk_in = ~mclk_in;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] s, e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// strobe held across one rising edge, driven at falling edges
	task automatic wr(input logic c, input reg_sel_t r, input logic [7:0] d);
		@(negedge mclk_in);
		chan_sel_in = c;
		reg_sel_in = r;
		wr_data_in = d;
		wr_en_in = 1;
		@(negedge mclk_in);
		wr_en_in = 0;
	endtask
	task automatic rd(input logic c, input reg_sel_t r);
		@(negedge mclk_in);
		chan_sel_in = c;
		reg_sel_in = r;
		rd_en_in = 1;
		@(negedge mclk_in);
		rd_en_in = 0;
		@(negedge mclk_in);
		rd_v = rd_data_out;
	endtask
	// program channel 0, let it settle, then count ticks over n cycles
	task automatic run(input logic [7:0] p, hi, lo, fr, input int n, es, eb);
		wr(0, REG_MODEM_CTRL, p);
		wr(0, REG_DIV_HIGH, hi);
		wr(0, REG_DIV_LOW, lo);
		wr(0, REG_DIV_FRAC, fr);
		ns = 0;
		nb = 0;
		n1 = 0;
		repeat (8) @(negedge mclk_in);
		repeat (n) begin
			@(negedge mclk_in);
			ns += sample_tick_out[0];
			nb += bit_tick_out[0];
			n1 += sample_tick_out[1];
		end
		chk("sample ticks", ns, es);
		chk("bit ticks", nb, eb);
		chk("other channel ticks", n1, n);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int c = 0; c < 2; c++) begin
			rd(c[0], REG_DIV_LOW);
			chk("low byte", rd_v, 16'h0001);
			rd(c[0], REG_DIV_HIGH);
			chk("high byte", rd_v, 16'h0000);
			rd(c[0], REG_DIV_FRAC);
			chk("fraction", rd_v, 16'h0000);
		end
		wr(1, REG_DIV_LOW, 8'h01);
	endtask
	task automatic t_prescale;
		run(8'hff, 8'h00, 8'h01, 8'h00, 64, 16, 1);
		rd(0, REG_MODEM_CTRL);
		chk("control", rd_v, 16'h0080);
	endtask
	task automatic t_divisor;
		run(8'h00, 8'h00, 8'h03, 8'h00, 96, 32, 2);
		run(8'h00, 8'h01, 8'h00, 8'h00, 600, 2, 0);
		run(8'h00, 8'h00, 8'h02, 8'h08, 80, 32, 2);
		// divisor 1 1/16 in 8X: one stretched period in sixteen
		run(8'h00, 8'h00, 8'h01, 8'h11, 64, 60, 8);
		rd(0, REG_DIV_FRAC);
		chk("fraction", rd_v, 16'h0011);
	endtask
	task automatic t_modes;
		logic [7:0] fr [3] = '{8'h10, 8'h20, 8'h30};
		int eb [3] = '{8, 16, 4};
		sample_rate_t er [3] = '{SAMPLE_8X, SAMPLE_4X, SAMPLE_16X};
		for (int i = 0; i < 3; i++) begin
			run(8'h00, 8'h00, 8'h01, fr[i], 64, 64, eb[i]);
			chk("rate", sample_rate_out[0], er[i]);
		end
	endtask
	// reset, scenarios, verdict
	initial begin
		repeat (3) @(negedge mclk_in);
		arst_n_in = 1;
		t_reset;
		t_prescale;
		t_divisor;
		t_modes;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge mclk_in);
		errors++;
		complete_run;
	end
endmodule
